// ---- rtl/brs_bus_release_ctrl.sv ----
// Behaviour
// - Select 0 times phase-two and chip selects from main clock; 1 from fast clock.
// - Release input low phase means bus release; high phase means processor stall.
// - Holding release low in high phase stalls each cycle; memory bus stays driven.
// - Phase-two output keeps toggling normally while the processor is stalled.
// - Release low in the low phase turns off the address output drivers.
// - During release, address pins are inputs; outside master reads or writes memory.
`timescale 1ns/1ps
`include "brs_defs.svh"

module brs_bus_release_ctrl
  import brs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Clock pins and source select
  input wire logic main_clock_in,
  input wire logic fast_clock_in,
  input wire logic phase_clock_source_select,
  // Bus control pins
  input wire logic bus_release_input,
  input wire logic write_enable_low,
  // Address pins, three-signal form
  input wire logic [`BRS_ADDR_W-1:0] addr_pin_in,
  output logic [`BRS_ADDR_W-1:0] addr_pin_out,
  output logic [`BRS_ADDR_W-1:0] addr_pin_oe,
  // Core side
  input wire logic [`BRS_ADDR_W-1:0] core_addr,
  input wire logic [`BRS_CS_W-1:0] core_cs_req,
  output logic core_stall_r,
  output logic bus_released_r,
  output brs_ext_acc_t ext_acc_r,
  output logic ext_acc_valid_r,
  // Clock and select outputs
  output logic phase_two_clock_out,
  output logic [`BRS_CS_W-1:0] chip_select_outputs_n
);

  logic [1:0] clk_lvl;
  logic [1:0] ctl_lvl;
  logic [`BRS_ADDR_W-1:0] addr_lvl;
  logic src_lvl;
  logic phi_rise;
  logic phi_fall;
  brs_owner_t owner_r;
  brs_owner_t owner_nxt;
  logic rel_low;
  logic wr_low;

  // Pin synchronisers for the clocks, control pins and address pins
  brs_pin_sync #(.W(2)) u_clk_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in({fast_clock_in, main_clock_in}),
    .level_out(clk_lvl)
  );

  brs_pin_sync #(.W(2)) u_ctl_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in({~write_enable_low, ~bus_release_input}),
    .level_out(ctl_lvl)
  );

  brs_pin_sync #(.W(`BRS_ADDR_W)) u_addr_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in(addr_pin_in),
    .level_out(addr_lvl)
  );

  // Control pins as active-high requests; reset level of the chain equals idle pins
  assign rel_low = ctl_lvl[0];
  assign wr_low = ctl_lvl[1];

  assign src_lvl = (phase_clock_source_select == `BRS_SRC_FAST) ? clk_lvl[1] : clk_lvl[0];
  assign phi_rise = src_lvl & ~phase_two_clock_out;
  assign phi_fall = ~src_lvl & phase_two_clock_out;

  // phase-two follows its source, independent of stall
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_two_clock_out <= 1'b0;
    end else begin
      phase_two_clock_out <= src_lvl;
    end
  end

  // chip selects timed by the same phase-two edges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_outputs_n <= `BRS_CS_IDLE;
    end else if (phi_rise) begin
      chip_select_outputs_n <= ~core_cs_req;
    end else if (phi_fall) begin
      chip_select_outputs_n <= `BRS_CS_IDLE;
    end
  end

  // phase decides meaning of release input
  always_comb begin
    owner_nxt = owner_r;
    if (phi_rise) begin
      // End of low phase: release decision
      if (rel_low) begin
        owner_nxt = OWN_EXT;
      end else if (owner_r == OWN_EXT) begin
        owner_nxt = OWN_CORE;
      end
    end else if (phi_fall) begin
      // End of high phase: stall decision
      if (rel_low && owner_r != OWN_EXT) begin
        owner_nxt = OWN_STALL;
      end else if (!rel_low && owner_r == OWN_STALL) begin
        owner_nxt = OWN_CORE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      owner_r <= OWN_CORE;
    end else begin
      owner_r <= owner_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_stall_r <= 1'b0;
      bus_released_r <= 1'b0;
    end else begin
      core_stall_r <= (owner_nxt == OWN_STALL);
      bus_released_r <= (owner_nxt == OWN_EXT);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_pin_out <= `BRS_ADDR_RST;
      addr_pin_oe <= '0;
    end else begin
      addr_pin_out <= core_addr;
      addr_pin_oe <= {`BRS_ADDR_W{owner_nxt != OWN_EXT}};
    end
  end

  // outside master access on each released high phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_acc_r <= '0;
      ext_acc_valid_r <= 1'b0;
    end else begin
      ext_acc_valid_r <= phi_fall && owner_r == OWN_EXT;
      if (phi_fall && owner_r == OWN_EXT) begin
        ext_acc_r.addr <= addr_lvl;
        ext_acc_r.write <= wr_low;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_phase_follows_src:
    assert property (phase_two_clock_out == $past(src_lvl))
    else $error("phase-two does not follow selected source");
  a_cs_idle_low:
    assert property (!phase_two_clock_out && !phi_rise |=> chip_select_outputs_n == `BRS_CS_IDLE)
    else $error("chip select active in phase-two low");
  a_cs_active_high:
    assert property (phi_rise |=> chip_select_outputs_n == ~$past(core_cs_req))
    else $error("chip select not taken at phase-two rise");
  a_stall_sample:
    assert property (phi_fall && rel_low && owner_r != OWN_EXT |=> core_stall_r)
    else $error("stall not taken at end of high phase");
  a_release_sample:
    assert property (phi_rise && rel_low |=> bus_released_r ##1 addr_pin_oe == '0)
    else $error("release not taken at end of low phase");
  a_stall_keeps_bus:
    assert property (core_stall_r |-> addr_pin_oe == '1)
    else $error("address bus floated during stall");
  a_stall_clock_runs:
    assert property (core_stall_r && phi_rise |=> phase_two_clock_out)
    else $error("phase-two held during stall");
  a_release_oe_off:
    assert property (bus_released_r |-> addr_pin_oe == '0)
    else $error("address drivers on while released");
  a_ext_access:
    assert property (phi_fall && owner_r == OWN_EXT |=> ext_acc_valid_r && ext_acc_r.write == $past(wr_low))
    else $error("outside access missing or wrong direction");
  a_ext_addr_taken:
    assert property (phi_fall && owner_r == OWN_EXT |=> ext_acc_r.addr == $past(addr_lvl))
    else $error("outside access address not taken from pins");
  a_resume_high:
    assert property (phi_fall && !rel_low && owner_r == OWN_STALL |=> !core_stall_r)
    else $error("no resume after release input seen high");
  a_stall_hold:
    assert property (core_stall_r && !phi_rise && !phi_fall |=> core_stall_r)
    else $error("stall dropped between phase edges");
  a_release_drop:
    assert property (phi_rise && !rel_low && owner_r == OWN_EXT |=> !bus_released_r)
    else $error("bus not returned after release input seen high");

  // Main scenarios
  c_stall: cover property (phi_fall && rel_low ##1 core_stall_r);
  c_ext_write: cover property (ext_acc_valid_r && ext_acc_r.write);
  c_release: cover property (bus_released_r ##[1:200] ext_acc_valid_r);
  c_fast_src: cover property (phase_clock_source_select && phi_rise);
  c_resume: cover property (core_stall_r ##1 !core_stall_r);

endmodule

// ---- rtl/brs_defs.svh ----
`ifndef BRS_DEFS_SVH
`define BRS_DEFS_SVH

// Bus widths
`define BRS_ADDR_W 16
`define BRS_CS_W 8

// Reset values
`define BRS_ADDR_RST 16'h0000
`define BRS_CS_IDLE 8'hFF

// Clock source select codes
`define BRS_SRC_MAIN 1'b0
`define BRS_SRC_FAST 1'b1

`endif

// ---- rtl/brs_pin_sync.sv ----
`timescale 1ns/1ps

module brs_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pin side
  input wire logic [W-1:0] pin_in,
  // Clean level
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Three-stage chain; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s2_r[i];
        end
      end
    end
  end

endmodule

// ---- rtl/brs_pkg.sv ----
`include "brs_defs.svh"

package brs_pkg;

  // Bus ownership per phase-two cycle
  typedef enum logic [2:0] {
    OWN_CORE = 3'b001,
    OWN_STALL = 3'b010,
    OWN_EXT = 3'b100
  } brs_owner_t;

  // One access by an outside master to internal memory
  typedef struct packed {
    logic [`BRS_ADDR_W-1:0] addr;
    logic write;
  } brs_ext_acc_t;

endpackage

// ---- tb/brs_far_model.sv ----
`timescale 1ns/1ps
`include "brs_defs.svh"

module brs_far_model (
  // Seen from the device
  input wire logic phase_two_clock_out,
  // Commands from the bench
  input wire logic stall_req,
  input wire logic rel_req,
  input wire logic [`BRS_ADDR_W-1:0] ext_addr,
  input wire logic ext_wr,
  // Pins into the device
  output logic main_clock_in,
  output logic fast_clock_in,
  output logic bus_release_input,
  output logic write_enable_low,
  output logic [`BRS_ADDR_W-1:0] addr_pin_in
);
  logic phi_bar_d = 1'b1;

  // fast clock never stretched; stalls go through the release pin only
  // main period is four fast periods
  initial begin
    main_clock_in = 1'b0;
    fast_clock_in = 1'b0;
  end
  always #1200 main_clock_in = ~main_clock_in;
  always #300 fast_clock_in = ~fast_clock_in;

  always @(phase_two_clock_out) phi_bar_d <= #10 ~phase_two_clock_out;

  // stall only in the high phase, release held low
  assign bus_release_input = ~rel_req & (phi_bar_d | ~stall_req);

  // pins carry the access only while releasing
  assign addr_pin_in = rel_req ? ext_addr : ~ext_addr;
  assign write_enable_low = rel_req ? ~ext_wr : ext_wr;
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "brs_defs.svh"

module tb;
  import brs_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic main_clock_in, fast_clock_in, sel, bus_release_input, write_enable_low;
  logic stall_req, rel_req, ext_wr, core_stall_r, bus_released_r, ext_acc_valid_r, phase_two_clock_out;
  logic [15:0] addr_pin_in, addr_pin_out, addr_pin_oe, core_addr, ext_addr;
  logic [7:0] core_cs_req, chip_select_outputs_n;
  brs_ext_acc_t ext_acc_r;
  int failures, num_checks, cyc;

  // Clock and hang limit
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end

  brs_bus_release_ctrl u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .main_clock_in(main_clock_in),
    .fast_clock_in(fast_clock_in), .phase_clock_source_select(sel), .bus_release_input(bus_release_input),
    .write_enable_low(write_enable_low), .addr_pin_in(addr_pin_in), .addr_pin_out(addr_pin_out),
    .addr_pin_oe(addr_pin_oe), .core_addr(core_addr), .core_cs_req(core_cs_req), .core_stall_r(core_stall_r),
    .bus_released_r(bus_released_r), .ext_acc_r(ext_acc_r), .ext_acc_valid_r(ext_acc_valid_r),
    .phase_two_clock_out(phase_two_clock_out), .chip_select_outputs_n(chip_select_outputs_n));

  brs_far_model u_far (.phase_two_clock_out(phase_two_clock_out), .stall_req(stall_req), .rel_req(rel_req),
    .ext_addr(ext_addr), .ext_wr(ext_wr), .main_clock_in(main_clock_in), .fast_clock_in(fast_clock_in),
    .bus_release_input(bus_release_input), .write_enable_low(write_enable_low), .addr_pin_in(addr_pin_in));

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Stall held over several phases, then lifted
  task automatic t_stall;
    int bad, tg;
    logic p;
    bad = 0;
    tg = 0;
    stall_req = 1'b1;
    for (int i = 0; i < 40 && core_stall_r !== 1'b1; i++) step(1);
    p = phase_two_clock_out;
    for (int i = 0; i < 60; i++) begin
      step(1);
      bad += int'(addr_pin_oe !== 16'hFFFF || addr_pin_out !== core_addr || core_stall_r !== 1'b1);
      tg += int'(phase_two_clock_out !== p);
      p = phase_two_clock_out;
    end
    chk("stall_bus", 17'h0, 17'(bad));
    chk("phi_toggles", 17'h1, {16'h0, tg >= 8});
    stall_req = 1'b0;
    for (int i = 0; i < 40 && core_stall_r !== 1'b0; i++) step(1);
    chk("resume", 17'h0, {16'h0, core_stall_r});
  endtask

  // Outside master access while released
  task automatic t_release(input logic wr, input logic [15:0] a);
    ext_addr = a;
    ext_wr = wr;
    rel_req = 1'b1;
    for (int i = 0; i < 40 && bus_released_r !== 1'b1; i++) step(1);
    step(1);
    chk("released", 17'h1, {16'h0, bus_released_r});
    chk("oe_off", 17'h0, {1'b0, addr_pin_oe});
    for (int i = 0; i < 40 && ext_acc_valid_r !== 1'b1; i++) step(1);
    chk("acc_valid", 17'h1, {16'h0, ext_acc_valid_r});
    chk("access", {a, wr}, ext_acc_r);
    rel_req = 1'b0;
    for (int i = 0; i < 40 && bus_released_r !== 1'b0; i++) step(1);
    step(2);
    chk("oe_back", 17'h0FFFF, {1'b0, addr_pin_oe});
  endtask

  // High time and chip selects follow the chosen clock
  task automatic t_source;
    int h;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      core_cs_req = 8'h05 << s;
      step(60);
      while (phase_two_clock_out !== 1'b0) step(1);
      while (phase_two_clock_out !== 1'b1) step(1);
      step(2);
      chk("cs_high", {9'h0, ~core_cs_req}, {9'h0, chip_select_outputs_n});
      h = 2;
      while (phase_two_clock_out === 1'b1) begin
        step(1);
        h++;
      end
      step(1);
      chk("cs_low", 17'h000FF, {9'h0, chip_select_outputs_n});
      chk("high_time", 17'h1, {16'h0, s ? (h >= 4 && h <= 8) : (h >= 22 && h <= 26)});
    end
  endtask

  task automatic close_out;
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    failures = 0;
    num_checks = 0;
    cyc = 0;
    sel = 1'b1;
    stall_req = 1'b0;
    rel_req = 1'b0;
    ext_addr = 16'h0000;
    ext_wr = 1'b0;
    core_addr = 16'h1234;
    core_cs_req = 8'h00;
    repeat (6) @(posedge sys_clk);
    chk("cs_reset", 17'h000FF, {9'h0, chip_select_outputs_n});
    #1 reset_n = 1'b1;
    step(30);
    t_stall();
    t_release(1'b1, 16'hA5C3);
    t_release(1'b0, 16'h5A3C);
    t_source();
    close_out();
  end
endmodule
